// ==== hw/rtcv_top.sv ====
// Calendar value register with per-register write synchronization on an AXI4-Lite slave.
//
// What this block does
// - A write to a synchronized register raises its busy flag until the copy completes.
// - A write to a register still synchronizing is dropped and flagged as an access error.
// - Each register synchronizes on its own, so a write to another one is taken at once.
// - The calendar advances only while the mode field selects calendar operation, value 2.
// - Calendar writes obey the write-protect guard and pass through the sync path.
// - Bits 31 to 26 hold a six-bit year offset from a base year of software's choice.
// - A year is a leap year when the two low bits of the year offset are zero.
// - Bits 25 to 22 hold the month, 1 to 12.
// - Bits 21 to 17 hold the day from 1 to the month's length, leap years included.
// - With 24-hour form the hour in bits 16 to 12 runs 0 to 23.
// - With 12-hour form the low hour bits run 1 to 12 and the top bit marks afternoon.
// - Bits 11 to 6 hold the minute, 0 to 59.
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/1ps
module rtcv_top import rtcv_pkg::*; #(
  parameter int AW = 8 // Register bus address width.
) (
  input wire logic core_clk, // Bus and block clock, 100 MHz.
  input wire logic rstn, // Synchronous reset, active low.
  input wire logic [AW-1:0] s_axi_awaddr, // Write address.
  input wire logic s_axi_awvalid, // Write address valid.
  output logic s_axi_awready, // Write address ready.
  input wire logic [31:0] s_axi_wdata, // Write data.
  input wire logic [3:0] s_axi_wstrb, // Write byte enables.
  input wire logic s_axi_wvalid, // Write data valid.
  output logic s_axi_wready, // Write data ready.
  output logic [1:0] s_axi_bresp, // Write response.
  output logic s_axi_bvalid, // Write response valid.
  input wire logic s_axi_bready, // Write response ready.
  input wire logic [AW-1:0] s_axi_araddr, // Read address.
  input wire logic s_axi_arvalid, // Read address valid.
  output logic s_axi_arready, // Read address ready.
  output logic [31:0] s_axi_rdata, // Read data.
  output logic [1:0] s_axi_rresp, // Read response.
  output logic s_axi_rvalid, // Read data valid.
  input wire logic s_axi_rready, // Read data ready.
  input wire logic sec_tick_pin, // One-second pulse from the slow oscillator.
  input wire logic write_protect, // Guard lock level from the access controller.
  output logic access_err, // One-cycle error pulse to the access guard.
  output logic irq // Level interrupt.
);
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Byte-lane merge of a bus write into an existing word.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ****************************************************************
  // Second tick input
  // ****************************************************************
  logic sec_meta_r;
  logic sec_sync_r;
  logic sec_prev_r;
  logic tick;

  // The pin is asynchronous, so two flops come first; edge detect compares the second with a third, delayed copy.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      sec_meta_r <= 1'b0;
      sec_sync_r <= 1'b0;
      sec_prev_r <= 1'b0;
    end else begin
      sec_meta_r <= sec_tick_pin;
      sec_sync_r <= sec_meta_r;
      sec_prev_r <= sec_sync_r;
    end
  end
  assign tick = sec_sync_r & ~sec_prev_r;

  // ****************************************************************
  // Write channel capture
  // ****************************************************************
  logic aw_hold_r, aw_hold_nxt;
  logic w_hold_r, w_hold_nxt;
  logic [AW-1:0] awaddr_r, awaddr_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt;
  logic do_wr;

  assign s_axi_awready = ~aw_hold_r & ~bvalid_r;
  assign s_axi_wready = ~w_hold_r & ~bvalid_r;
  assign do_wr = aw_hold_r & w_hold_r & ~bvalid_r;

  // ****************************************************************
  // Registers and synchronization
  // ****************************************************************
  logic [31:0] cal_r, cal_nxt;
  logic [31:0] cal_pend_r, cal_pend_nxt;
  logic [31:0] ctrl_r, ctrl_nxt;
  logic [31:0] ctrl_pend_r, ctrl_pend_nxt;
  logic [3:0] cal_cnt_r, cal_cnt_nxt;
  logic [3:0] ctl_cnt_r, ctl_cnt_nxt;
  logic [2:0] mask_r, mask_nxt;
  logic [2:0] stat_r, stat_nxt;
  logic err_r, err_nxt;
  logic cal_busy, ctl_busy, cal_apply, ctl_apply, running;
  logic wr_cal, wr_ctl, drop;
  logic [31:0] step_out;
  logic [2:0] stat_clr;

  assign cal_busy = cal_cnt_r != 4'h0;
  assign ctl_busy = ctl_cnt_r != 4'h0;
  assign cal_apply = cal_cnt_r == 4'h1;
  assign ctl_apply = ctl_cnt_r == 4'h1;
  assign running = ctrl_r[CTRL_EN_BIT] &&
                   ctrl_r[CTRL_MODE_LSB +: 2] == MODE_CALENDAR;
  assign wr_cal = do_wr && awaddr_r[7:0] == CAL_OFS;
  assign wr_ctl = do_wr && awaddr_r[7:0] == CTRL_OFS;
  // A write is refused while its own register is still copying or the guard is locked.
  assign drop = (wr_cal && (cal_busy || write_protect)) ||
                (wr_ctl && (ctl_busy || write_protect));

  rtcv_cal_step u_step (
    .cal_in(cal_r),
    .fmt_12h(ctrl_r[CTRL_FMT_BIT]),
    .cal_out(step_out)
  );

  // Write handshake and register updates; the calendar and control registers each have their own countdown.
  always_comb begin
    aw_hold_nxt = aw_hold_r | (s_axi_awvalid & s_axi_awready);
    w_hold_nxt = w_hold_r | (s_axi_wvalid & s_axi_wready);
    awaddr_nxt = (s_axi_awvalid & s_axi_awready) ? s_axi_awaddr : awaddr_r;
    wdata_nxt = (s_axi_wvalid & s_axi_wready) ? s_axi_wdata : wdata_r;
    wstrb_nxt = (s_axi_wvalid & s_axi_wready) ? s_axi_wstrb : wstrb_r;
    bvalid_nxt = bvalid_r & ~s_axi_bready;
    bresp_nxt = bresp_r;
    cal_pend_nxt = cal_pend_r;
    ctrl_pend_nxt = ctrl_pend_r;
    cal_cnt_nxt = cal_busy ? 4'(cal_cnt_r - 4'h1) : cal_cnt_r;
    ctl_cnt_nxt = ctl_busy ? 4'(ctl_cnt_r - 4'h1) : ctl_cnt_r;
    mask_nxt = mask_r;
    err_nxt = drop;
    if (do_wr) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_OK;
      if (drop) begin
        bresp_nxt = RESP_SLVERR;
      end else if (wr_cal) begin
        cal_pend_nxt = merge(cal_r, wdata_r, wstrb_r);
        cal_cnt_nxt = SYNC_CYC;
      end else if (wr_ctl) begin
        ctrl_pend_nxt = merge(ctrl_r, wdata_r, wstrb_r) & CTRL_WMASK;
        ctl_cnt_nxt = SYNC_CYC;
      end else if (awaddr_r[7:0] == MASK_OFS) begin
        mask_nxt = wdata_r[2:0] & {3{wstrb_r[0]}} | mask_r & {3{~wstrb_r[0]}};
      end else begin
        bresp_nxt = RESP_SLVERR;
      end
    end
    // A completing copy overrides the tick in the same cycle.
    if (cal_apply) begin
      cal_nxt = cal_pend_r;
    end else if (tick && running) begin
      cal_nxt = step_out;
    end else begin
      cal_nxt = cal_r;
    end
    ctrl_nxt = ctl_apply ? ctrl_pend_r : ctrl_r;
    // Set wins over the read clear, so no event is lost.
    stat_nxt = (stat_r & ~stat_clr) | {cal_apply | ctl_apply, drop, tick & running};
  end

  // Register stage for the write side and the block state.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OK;
      cal_r <= CAL_RST;
      cal_pend_r <= CAL_RST;
      ctrl_r <= CTRL_RST;
      ctrl_pend_r <= CTRL_RST;
      cal_cnt_r <= 4'h0;
      ctl_cnt_r <= 4'h0;
      mask_r <= MASK_RST;
      stat_r <= 3'h0;
      err_r <= 1'b0;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      cal_r <= cal_nxt;
      cal_pend_r <= cal_pend_nxt;
      ctrl_r <= ctrl_nxt;
      ctrl_pend_r <= ctrl_pend_nxt;
      cal_cnt_r <= cal_cnt_nxt;
      ctl_cnt_r <= ctl_cnt_nxt;
      mask_r <= mask_nxt;
      stat_r <= stat_nxt;
      err_r <= err_nxt;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign access_err = err_r;
  assign irq = |(stat_r & mask_r);

  // ****************************************************************
  // Read channel
  // ****************************************************************
  logic rvalid_r, rvalid_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [1:0] rresp_r, rresp_nxt;
  logic rd_take;

  assign s_axi_arready = ~rvalid_r;
  assign rd_take = s_axi_arvalid & ~rvalid_r;
  assign stat_clr = (rd_take && s_axi_araddr[7:0] == STAT_OFS) ? 3'h7 : 3'h0;

  // Reads of the calendar return the settled value, never a half-copied one.
  always_comb begin
    rvalid_nxt = rvalid_r & ~s_axi_rready;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (rd_take) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OK;
      case (s_axi_araddr[7:0])
        CAL_OFS: rdata_nxt = cal_r;
        CTRL_OFS: rdata_nxt = ctrl_r;
        MASK_OFS: rdata_nxt = {29'h0, mask_r};
        STAT_OFS: rdata_nxt = {29'h0, stat_r};
        BUSY_OFS: rdata_nxt = {30'h0, cal_busy, ctl_busy};
        default: begin
          rdata_nxt = 32'h00000000;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
  end

  // Register stage for the read side.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= RESP_OK;
    end else begin
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);

  busy_set_a: assert property (wr_cal && !drop |=> cal_busy)
    else $error("calendar busy not raised after accepted write");
  busy_clear_a: assert property ($rose(cal_busy) |-> cal_busy [*4] ##1 !cal_busy)
    else $error("calendar busy did not last exactly the sync time");
  drop_err_a: assert property (wr_cal && cal_busy |=> access_err && bresp_r == RESP_SLVERR)
    else $error("write during sync not reported");
  drop_keep_a: assert property (wr_cal && cal_busy |=> $stable(cal_pend_r) &&
    cal_cnt_r == 4'($past(cal_cnt_r) - 4'h1))
    else $error("write during sync was not discarded");
  par_sync_a: assert property (wr_ctl && !ctl_busy && !write_protect && cal_busy
    |=> ctl_busy && !access_err)
    else $error("second register refused while first synchronizing");
  mode_gate_a: assert property (tick && !running && !cal_apply |=> $stable(cal_r))
    else $error("calendar moved outside calendar mode");
  prot_drop_a: assert property (wr_cal && write_protect && !cal_busy
    |=> access_err && !cal_busy ##1 !cal_busy[*2])
    else $error("protected write was taken");
  leap_day_a: assert property (cal_r[MONTH_LSB +: 4] == MON_FEB &&
    cal_r[DAY_LSB +: 5] == DAYS_FEB && step_out[DAY_LSB +: 5] == DAYS_FEB_LEAP
    |-> cal_r[YEAR_LSB +: 2] == 2'h0)
    else $error("leap day in a non-leap year");
  month_rng_a: assert property (cal_r[MONTH_LSB +: 4] inside {[1:12]}
    |-> step_out[MONTH_LSB +: 4] inside {[1:12]})
    else $error("month left its range");
  hour24_a: assert property (!ctrl_r[CTRL_FMT_BIT] && cal_r[HOUR_LSB +: 5] <= HOUR24_MAX
    |-> step_out[HOUR_LSB +: 5] <= HOUR24_MAX)
    else $error("24-hour value out of range");
  hour12_a: assert property (ctrl_r[CTRL_FMT_BIT] && cal_r[HOUR_LSB +: 4] inside {[1:12]}
    |-> step_out[HOUR_LSB +: 4] inside {[1:12]})
    else $error("12-hour value out of range");
  sec_wrap_a: assert property (cal_r[SEC_LSB +: 6] == SEC_MAX && cal_r[MIN_LSB +: 6] < MIN_MAX
    |-> step_out[SEC_LSB +: 6] == 6'h00 &&
        step_out[MIN_LSB +: 6] == 6'(cal_r[MIN_LSB +: 6] + 6'h01))
    else $error("second wrap did not carry into minutes");

  drop_c: cover property (wr_cal && cal_busy);
  parallel_c: cover property (cal_busy && ctl_busy);
  tick_c: cover property (tick && running);
  irq_c: cover property ($rose(irq));
endmodule

// ==== hw/rtcv_pkg.sv ====
// Shared constants for the calendar value block: register map, fields, resets, timing.
package rtcv_pkg;
  // ****************************************************************
  // Register offsets (byte addresses on the register bus)
  // ****************************************************************
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] MASK_OFS = 8'h08;
  localparam logic [7:0] STAT_OFS = 8'h0C;
  localparam logic [7:0] BUSY_OFS = 8'h10;
  localparam logic [7:0] CAL_OFS = 8'h18;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [31:0] CAL_RST = 32'h00000000;
  localparam logic [31:0] CTRL_RST = 32'h00000000;
  localparam logic [2:0] MASK_RST = 3'h0;

  // ****************************************************************
  // Control fields, busy bits and event bits
  // ****************************************************************
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_MODE_LSB = 2;
  localparam int CTRL_FMT_BIT = 6;
  localparam logic [31:0] CTRL_WMASK = 32'h0000004D;
  localparam logic [1:0] MODE_CALENDAR = 2'h2;
  localparam int BUSY_CTRL_BIT = 0;
  localparam int BUSY_CAL_BIT = 1;
  localparam int EV_SEC_BIT = 0;
  localparam int EV_ERR_BIT = 1;
  localparam int EV_SYNC_BIT = 2;

  // ****************************************************************
  // Calendar value fields
  // ****************************************************************
  localparam int YEAR_LSB = 26;
  localparam int MONTH_LSB = 22;
  localparam int DAY_LSB = 17;
  localparam int HOUR_LSB = 12;
  localparam int MIN_LSB = 6;
  localparam int SEC_LSB = 0;
  localparam logic [5:0] SEC_MAX = 6'h3B;
  localparam logic [5:0] MIN_MAX = 6'h3B;
  localparam logic [4:0] HOUR24_MAX = 5'h17;
  localparam logic [3:0] HOUR12_MAX = 4'hC;
  localparam logic [3:0] HOUR12_PRE = 4'hB;
  localparam logic [3:0] HOUR12_FIRST = 4'h1;
  localparam logic [4:0] DAY_FIRST = 5'h01;
  localparam logic [3:0] MONTH_FIRST = 4'h1;
  localparam logic [3:0] MONTH_MAX = 4'hC;
  localparam logic [3:0] MON_FEB = 4'h2;
  localparam logic [4:0] DAYS_LONG = 5'h1F;
  localparam logic [4:0] DAYS_SHORT = 5'h1E;
  localparam logic [4:0] DAYS_FEB = 5'h1C;
  localparam logic [4:0] DAYS_FEB_LEAP = 5'h1D;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam logic [3:0] SYNC_CYC = 4'h4;
endpackage

// ==== hw/rtcv_cal_step.sv ====
// Combinational one-second advance of the packed calendar value.
`timescale 1ns/1ps
module rtcv_cal_step import rtcv_pkg::*; (
  input wire logic [31:0] cal_in, // Current calendar value.
  input wire logic fmt_12h, // High selects 12-hour form.
  output logic [31:0] cal_out // Value one second later.
);
  // Month length; February follows the leap test on the year offset.
  function automatic logic [4:0] month_len(input logic [3:0] mon, input logic [5:0] yr);
    logic [4:0] len;
    len = DAYS_LONG;
    case (mon)
      MON_FEB: len = (yr[1:0] == 2'h0) ? DAYS_FEB_LEAP : DAYS_FEB;
      4'h4, 4'h6, 4'h9, 4'hB: len = DAYS_SHORT;
      default: len = DAYS_LONG;
    endcase
    return len;
  endfunction

  // Carry chain from seconds up to the year; out-of-range input wraps to the first value.
  always_comb begin
    logic [5:0] yr;
    logic [3:0] mon;
    logic [4:0] day;
    logic [4:0] hr;
    logic [5:0] mn;
    logic [5:0] sc;
    logic c_min;
    logic c_hr;
    logic c_day;
    logic c_mon;
    yr = cal_in[YEAR_LSB +: 6];
    mon = cal_in[MONTH_LSB +: 4];
    day = cal_in[DAY_LSB +: 5];
    hr = cal_in[HOUR_LSB +: 5];
    mn = cal_in[MIN_LSB +: 6];
    sc = cal_in[SEC_LSB +: 6];
    c_min = 1'b0;
    c_hr = 1'b0;
    c_day = 1'b0;
    c_mon = 1'b0;
    if (sc >= SEC_MAX) begin
      sc = 6'h00;
      c_min = 1'b1;
    end else begin
      sc = 6'(sc + 6'h01);
    end
    if (c_min) begin
      if (mn >= MIN_MAX) begin
        mn = 6'h00;
        c_hr = 1'b1;
      end else begin
        mn = 6'(mn + 6'h01);
      end
    end
    if (c_hr && fmt_12h) begin
      if (hr[3:0] == HOUR12_PRE) begin
        c_day = hr[4];
        hr = {~hr[4], HOUR12_MAX};
      end else if (hr[3:0] >= HOUR12_MAX) begin
        hr = {hr[4], HOUR12_FIRST};
      end else begin
        hr = {hr[4], 4'(hr[3:0] + 4'h1)};
      end
    end else if (c_hr) begin
      if (hr >= HOUR24_MAX) begin
        hr = 5'h00;
        c_day = 1'b1;
      end else begin
        hr = 5'(hr + 5'h01);
      end
    end
    if (c_day) begin
      if (day >= month_len(mon, yr)) begin
        day = DAY_FIRST;
        c_mon = 1'b1;
      end else begin
        day = 5'(day + 5'h01);
      end
    end
    if (c_mon) begin
      if (mon >= MONTH_MAX) begin
        mon = MONTH_FIRST;
        yr = 6'(yr + 6'h01);
      end else begin
        mon = 4'(mon + 4'h1);
      end
    end
    cal_out = {yr, mon, day, hr, mn, sc};
  end
endmodule

// ==== verif/tb_rtcv_top.sv ====
// Self-checking testbench for the calendar value block over its register bus.
`timescale 1ns/1ps
module tb_rtcv_top import rtcv_pkg::*;;
  // ****************************************************************
  // Stimulus signals and the block under test
  // ****************************************************************
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00;
  logic s_axi_awvalid = 1'b0;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b1;
  logic [7:0] s_axi_araddr = 8'h00;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_rready = 1'b1;
  logic sec_tick_pin = 1'b0;
  logic write_protect = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic access_err, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rd_d;
  logic [1:0] rd_r;
  int fail_count = 0;
  int num_checks = 0;

  // The clock toggles every half period of 5 ns.
  always #5 core_clk = ~core_clk;

  rtcv_top #(.AW(8)) i_rtcv_top (.core_clk(core_clk), .rstn(rstn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sec_tick_pin(sec_tick_pin),
    .write_protect(write_protect), .access_err(access_err), .irq(irq));

  // ****************************************************************
  // Compare, bus and helper tasks
  // ****************************************************************
  task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: response %h expected %h", $time, got, exp);
    end
  endtask

  // Write master; bready stays high, so the answer is taken where it is first seen.
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] exp_resp, input logic exp_err);
    logic aw_done;
    logic w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_wvalid <= 1'b1;
    // No limit of its own: only the watchdog ends a hung write.
    forever begin
      @(posedge core_clk);
      if (s_axi_bvalid === 1'b1) begin
        chk_resp(s_axi_bresp, exp_resp);
        if (exp_err !== 1'bx) begin
          chk_val({31'h0, access_err}, {31'h0, exp_err});
        end
        break;
      end
      if (!aw_done && s_axi_awready === 1'b1) begin
        aw_done = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w_done && s_axi_wready === 1'b1) begin
        w_done = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
  endtask

  task automatic rd_raw(input logic [7:0] a);
    logic taken;
    taken = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    // No limit of its own: only the watchdog ends a hung read.
    forever begin
      @(posedge core_clk);
      if (s_axi_rvalid === 1'b1) begin
        rd_d = s_axi_rdata;
        rd_r = s_axi_rresp;
        break;
      end
      if (!taken && s_axi_arready === 1'b1) begin
        taken = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] exp_resp);
    rd_raw(a);
    chk_val(rd_d, exp);
    chk_resp(rd_r, exp_resp);
  endtask

  // Poll both busy flags clear before touching a synchronized register again.
  task automatic wait_idle;
    for (int i = 0; i < 20; i++) begin
      rd_raw(BUSY_OFS);
      if (rd_d[1:0] === 2'b00) begin
        break;
      end
    end
    chk_val(rd_d, 32'h00000000);
  endtask

  // One slow-oscillator second; the pulse is long enough for the two-flop input sync.
  task automatic tick;
    @(posedge core_clk);
    sec_tick_pin <= 1'b1;
    repeat (4) @(posedge core_clk);
    sec_tick_pin <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask

  function automatic logic [31:0] cv(input logic [5:0] y, input logic [3:0] mo,
      input logic [4:0] d, input logic [4:0] h, input logic [5:0] mi, input logic [5:0] s);
    return {y, mo, d, h, mi, s};
  endfunction

  task automatic run_tick(input logic [31:0] ctrl, input logic [31:0] st, input logic [31:0] ex);
    wr(CTRL_OFS, ctrl, 4'hF, 2'h0, 1'b0);
    wr(CAL_OFS, st, 4'hF, 2'h0, 1'b0);
    wait_idle();
    tick();
    rd(CAL_OFS, ex, 2'h0);
  endtask

  task automatic final_report;
    if (fail_count == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Watchdog: the sequence needs under a thousand cycles, so 30000 cycles means a hang.
  initial begin
    #300000;
    fail_count++;
    $display("Error at %0t: watchdog expired", $time);
    final_report();
  end

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    rd(CAL_OFS, 32'h00000000, 2'h0);
    rd(CTRL_OFS, 32'h00000000, 2'h0);
    rd(MASK_OFS, 32'h00000000, 2'h0);
    rd(STAT_OFS, 32'h00000000, 2'h0);
    rd(BUSY_OFS, 32'h00000000, 2'h0);
    // Accepted write raises busy; a second write during the sync is dropped.
    wr(CAL_OFS, cv(6'h01, 4'h3, 5'h0A, 5'h08, 6'h1E, 6'h00), 4'hF, 2'h0, 1'b0);
    wr(CAL_OFS, cv(6'h02, 4'h4, 5'h0B, 5'h09, 6'h1F, 6'h01), 4'hF, 2'h2, 1'b1);
    rd(BUSY_OFS, 32'h00000000, 2'h0);
    rd(CAL_OFS, cv(6'h01, 4'h3, 5'h0A, 5'h08, 6'h1E, 6'h00), 2'h0);
    wr(CAL_OFS, cv(6'h03, 4'h5, 5'h0C, 5'h0A, 6'h20, 6'h02), 4'hF, 2'h0, 1'b0);
    rd(BUSY_OFS, 32'h00000002, 2'h0);
    wait_idle();
    wr(CAL_OFS, 32'h00000011, 4'hF, 2'h0, 1'b0);
    wr(CTRL_OFS, 32'h00000000, 4'hF, 2'h0, 1'b0);
    wait_idle();
    rd(STAT_OFS, 32'h00000006, 2'h0);
    rd(STAT_OFS, 32'h00000000, 2'h0);
    wr(CAL_OFS, cv(6'h03, 4'h5, 5'h0C, 5'h0A, 6'h20, 6'h02), 4'hF, 2'h0, 1'b0);
    wait_idle();
    wr(CAL_OFS, 32'h00000005, 4'h1, 2'h0, 1'b0);
    wait_idle();
    rd(CAL_OFS, cv(6'h03, 4'h5, 5'h0C, 5'h0A, 6'h20, 6'h05), 2'h0);
    write_protect <= 1'b1;
    wr(CAL_OFS, 32'h00000000, 4'hF, 2'h2, 1'b1);
    write_protect <= 1'b0;
    rd(CAL_OFS, cv(6'h03, 4'h5, 5'h0C, 5'h0A, 6'h20, 6'h05), 2'h0);
    rd(8'h04, 32'h00000000, 2'h2);
    wr(BUSY_OFS, 32'h00000003, 4'hF, 2'h2, 1'b0);
    // Carries through every field; mode 1 must leave the value alone.
    run_tick(32'h05, cv(6'h00, 4'h1, 5'h01, 5'h00, 6'h00, 6'h00),
             cv(6'h00, 4'h1, 5'h01, 5'h00, 6'h00, 6'h00));
    run_tick(32'h09, cv(6'h03, 4'h2, 5'h1C, 5'h09, 6'h0F, 6'h3B),
             cv(6'h03, 4'h2, 5'h1C, 5'h09, 6'h10, 6'h00));
    run_tick(32'h09, cv(6'h02, 4'h1, 5'h1F, 5'h0A, 6'h3B, 6'h3B),
             cv(6'h02, 4'h1, 5'h1F, 5'h0B, 6'h00, 6'h00));
    run_tick(32'h09, cv(6'h00, 4'h2, 5'h1C, 5'h17, 6'h3B, 6'h3B),
             cv(6'h00, 4'h2, 5'h1D, 5'h00, 6'h00, 6'h00));
    run_tick(32'h09, cv(6'h00, 4'h2, 5'h1D, 5'h17, 6'h3B, 6'h3B),
             cv(6'h00, 4'h3, 5'h01, 5'h00, 6'h00, 6'h00));
    run_tick(32'h09, cv(6'h01, 4'h2, 5'h1C, 5'h17, 6'h3B, 6'h3B),
             cv(6'h01, 4'h3, 5'h01, 5'h00, 6'h00, 6'h00));
    run_tick(32'h09, cv(6'h01, 4'h4, 5'h1E, 5'h17, 6'h3B, 6'h3B),
             cv(6'h01, 4'h5, 5'h01, 5'h00, 6'h00, 6'h00));
    run_tick(32'h09, cv(6'h05, 4'hC, 5'h1F, 5'h17, 6'h3B, 6'h3B),
             cv(6'h06, 4'h1, 5'h01, 5'h00, 6'h00, 6'h00));
    run_tick(32'h49, cv(6'h01, 4'h1, 5'h05, 5'h0B, 6'h3B, 6'h3B),
             cv(6'h01, 4'h1, 5'h05, 5'h1C, 6'h00, 6'h00));
    run_tick(32'h49, cv(6'h01, 4'h1, 5'h05, 5'h1B, 6'h3B, 6'h3B),
             cv(6'h01, 4'h1, 5'h06, 5'h0C, 6'h00, 6'h00));
    run_tick(32'h49, cv(6'h01, 4'h1, 5'h05, 5'h0C, 6'h3B, 6'h3B),
             cv(6'h01, 4'h1, 5'h05, 5'h01, 6'h00, 6'h00));
    // Second event raises the interrupt only while unmasked; a status read clears it.
    wr(MASK_OFS, 32'h00000001, 4'hF, 2'h0, 1'b0);
    rd(MASK_OFS, 32'h00000001, 2'h0);
    rd_raw(STAT_OFS);
    chk_val({31'h0, irq}, 32'h00000000);
    tick();
    chk_val({31'h0, irq}, 32'h00000001);
    rd(STAT_OFS, 32'h00000001, 2'h0);
    chk_val({31'h0, irq}, 32'h00000000);
    wr(MASK_OFS, 32'h00000000, 4'hF, 2'h0, 1'b0);
    tick();
    chk_val({31'h0, irq}, 32'h00000000);
    rd(STAT_OFS, 32'h00000001, 2'h0);
    final_report();
  end
endmodule
